// ---- lbc_host_model.sv ----
// Purpose: Microprocessor model that writes and reads register bytes
// Assumes: The register port changes at the falling edge
// Notes:   Bit 2 of the enable register is always sent as its default
`timescale 1ns/1ps
module lbc_host_model
   import lbc_pkg::*;
(
   // Clock
   input  wire logic       core_clk,
   // Register port
   output logic            regWrite,
   output logic      [7:0] regAddr,
   output logic      [7:0] regWdata,
   input  wire logic [7:0] regRdata
);
   // Idle bus at time zero
   initial begin
      regWrite = 1'b0;
      regAddr  = 8'h00;
      regWdata = 8'h00;
   end
   // One strobe per byte, then data no longer shows the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      regAddr  = a;
      regWdata = (a == LBC_ADDR_EN_STAT) ? {d[7:3], LBC_WRITE_EX_RESET, d[1:0]} : d;
      regWrite = 1'b1;
      @(negedge core_clk);
      regWrite = 1'b0;
      regWdata = ~regWdata;
   endtask : wr
   // Address held over two edges before the sample
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk);
      regAddr = a;
      repeat (2) @(negedge core_clk);
      d = regRdata;
   endtask : rd
endmodule : lbc_host_model

// ---- lbc_pkg.sv ----
// Purpose: Constants for the LED boost converter control register bank
// Assumes: 8-bit registers addressed by an 8-bit register index
// Notes:   Default values of read-only registers are parameters of the top
package lbc_pkg;
   localparam logic [7:0] LBC_ADDR_RO_A     = 8'h40;
   localparam logic [7:0] LBC_ADDR_RO_B     = 8'h41;
   localparam logic [7:0] LBC_ADDR_EN_STAT  = 8'h42;
   localparam logic [7:0] LBC_ADDR_THR_SEL  = 8'h43;
   localparam int         LBC_BIT_ENABLE    = 0;
   localparam int         LBC_BIT_POWER_OK  = 1;
   localparam int         LBC_BIT_WRITE_EX  = 2;
   localparam int         LBC_SEL_WIDTH     = 6;
   localparam logic [5:0] LBC_SEL_RESET     = 6'h3f;
   localparam logic       LBC_ENABLE_RESET  = 1'b0;
   localparam logic       LBC_WRITE_EX_RESET = 1'b0;
   // Threshold decode in quarter volts: top setting, low and high range bases
   localparam logic [6:0] LBC_QV_RESET      = 7'h72;
   localparam logic [6:0] LBC_QV_BASE_LO    = 7'h14;
   localparam logic [6:0] LBC_QV_BASE_HI    = 7'h34;
   localparam int         LBC_SYNC_STAGES   = 2;
endpackage : lbc_pkg

// ---- lbc_regs.sv ----
// Purpose: Register bank and enable logic of the LED boost converter
// Assumes: Register port from the serial bus decoder on core_clk
// Notes:   Threshold decode is given in units of 0.25 V
//          Pin levels reach the enable logic three edges after they change,
//          and the power-OK flag one edge later, as it follows converterOn
//          Read data lag their address by one edge
// Functional notes
// - Registers 0x40 and 0x41 are read-only in all eight bits with part-dependent contents.
// - Bit 0 of 0x42 enables the converter, but only while the enable pin is high.
// - A low pushbutton input also enables the converter, otherwise it is off.
// - Bit 1 of 0x42 reads 1 when output is good and 0 when sense exceeds threshold.
// - Register 0x43 holds a writable 6-bit select in bits 5:0, bits 7:6 read-only.
// - The select decodes to 5+2*s[4:3]+0.25*s[2:0] or 13+4*s[4:3]+0.5*s[2:0] volts.
// - The threshold resets to its highest setting of 28.5 V.
`timescale 1ns/1ps
module lbc_regs
   import lbc_pkg::*;
#(
   parameter logic [7:0] RO_A_VALUE  = 8'h00,
   parameter logic [7:0] RO_B_VALUE  = 8'h00,
   parameter logic [4:0] EN_HI_VALUE = 5'h00,
   parameter logic [1:0] THR_HI_VALUE = 2'h0
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       resetn,
   // Register port
   input  wire logic       regWrite,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWdata,
   output logic      [7:0] regRdata,
   // Pins and converter
   input  wire logic       converterEnablePin,
   input  wire logic       pushbuttonInputN,
   input  wire logic       overvoltageTrip,
   output logic            converterOn,
   output logic      [6:0] thresholdQuarterVolts,
   output logic      [5:0] thresholdSelect
);
   logic       enableBit;
   logic       writeExact;
   logic       powerOk;
   logic [2:0] pinSync;
   logic       enPinS;
   logic       pushPressed;
   logic       tripS;
   logic [7:0] next_rdata;

   // Synchronise pin levels; the pushbutton travels as a press level so that
   // the cleared synchroniser reads as released and no false enable follows reset
   lbc_sync #(.WIDTH(3)) uSync (
      .core_clk (core_clk),
      .resetn   (resetn),
      .asyncIn  ({converterEnablePin, ~pushbuttonInputN, overvoltageTrip}),
      .syncOut  (pinSync)
   );
   assign enPinS = pinSync[2];
   assign pushPressed = pinSync[1];
   assign tripS  = pinSync[0];

   // Enable and write-exact bits, other bits of 0x42 ignore writes
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         enableBit  <= LBC_ENABLE_RESET;
         writeExact <= LBC_WRITE_EX_RESET;
      end else if (regWrite && regAddr == LBC_ADDR_EN_STAT) begin
         enableBit  <= regWdata[LBC_BIT_ENABLE];
         writeExact <= regWdata[LBC_BIT_WRITE_EX];
      end
   end

   // Threshold select, bits 7:6 never stored
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         thresholdSelect <= LBC_SEL_RESET;
      end else if (regWrite && regAddr == LBC_ADDR_THR_SEL) begin
         thresholdSelect <= regWdata[LBC_SEL_WIDTH-1:0];
      end
   end

   // Power-OK flag follows converterOn, cleared while the trip comparator is set
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         powerOk <= 1'b0;
      end else begin
         powerOk <= converterOn && !tripS;
      end
   end

   // Converter enable from register with pin, or pushbutton
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         converterOn <= 1'b0;
      end else begin
         converterOn <= (enPinS && enableBit) || pushPressed;
      end
   end

   // Threshold decode in quarter volts
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         thresholdQuarterVolts <= LBC_QV_RESET;
      end else if (!thresholdSelect[5]) begin
         thresholdQuarterVolts <= LBC_QV_BASE_LO + {2'h0, thresholdSelect[4:3], 3'h0}
                                  + {4'h0, thresholdSelect[2:0]};
      end else begin
         thresholdQuarterVolts <= LBC_QV_BASE_HI + {1'h0, thresholdSelect[4:3], 4'h0}
                                  + {3'h0, thresholdSelect[2:0], 1'b0};
      end
   end

   // Read mux
   always_comb begin
      next_rdata = 8'h00;
      case (regAddr)
         LBC_ADDR_RO_A:    next_rdata = RO_A_VALUE;
         LBC_ADDR_RO_B:    next_rdata = RO_B_VALUE;
         LBC_ADDR_EN_STAT: next_rdata = {EN_HI_VALUE, writeExact, powerOk, enableBit};
         LBC_ADDR_THR_SEL: next_rdata = {THR_HI_VALUE, thresholdSelect};
         default:          next_rdata = 8'h00;
      endcase
   end

   // Registered read data
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         regRdata <= 8'h00;
      end else begin
         regRdata <= next_rdata;
      end
   end

   // Refuse a select width that the decode cannot serve
   if (LBC_SEL_WIDTH != 6) begin : g_sel_width_check
      $error("threshold select must be six bits wide");
   end

   // Reset values at the first edge after release
   a_sel_reset: assert property (@(posedge core_clk)
      $rose(resetn) |-> thresholdSelect == LBC_SEL_RESET)
      else $error("threshold not at top after reset");
   a_qv_reset: assert property (@(posedge core_clk)
      $rose(resetn) |-> thresholdQuarterVolts == LBC_QV_RESET)
      else $error("threshold decode not at top after reset");
   a_on_reset: assert property (@(posedge core_clk)
      $rose(resetn) |-> !converterOn)
      else $error("converter on right after reset");
   a_en_reset: assert property (@(posedge core_clk)
      $rose(resetn) |-> !enableBit)
      else $error("enable bit set right after reset");

   // Read-only registers and read-back of the mixed registers
   a_ro_write: assert property (@(posedge core_clk) disable iff (!resetn)
      regWrite && regAddr == LBC_ADDR_RO_A |=> ##1 regRdata == RO_A_VALUE || $past(regAddr) != LBC_ADDR_RO_A)
      else $error("read-only register changed");
   a_ro_b_read: assert property (@(posedge core_clk) disable iff (!resetn)
      regAddr == LBC_ADDR_RO_B |=> regRdata == RO_B_VALUE)
      else $error("second read-only register misread");
   a_en_rdata: assert property (@(posedge core_clk) disable iff (!resetn)
      regAddr == LBC_ADDR_EN_STAT |=> regRdata == {EN_HI_VALUE, $past(writeExact), $past(powerOk), $past(enableBit)})
      else $error("enable register misread");
   a_thr_rdata: assert property (@(posedge core_clk) disable iff (!resetn)
      regAddr == LBC_ADDR_THR_SEL |=> regRdata == {THR_HI_VALUE, $past(thresholdSelect)})
      else $error("threshold register misread");
   a_unmapped_read: assert property (@(posedge core_clk) disable iff (!resetn)
      (regAddr < LBC_ADDR_RO_A || regAddr > LBC_ADDR_THR_SEL) |=> regRdata == 8'h00)
      else $error("unmapped address read nonzero");

   // Writable bits update, the rest hold
   a_en_write: assert property (@(posedge core_clk) disable iff (!resetn)
      regWrite && regAddr == LBC_ADDR_EN_STAT |=> enableBit == $past(regWdata[0]))
      else $error("enable bit not written");
   a_wex_write: assert property (@(posedge core_clk) disable iff (!resetn)
      regWrite && regAddr == LBC_ADDR_EN_STAT |=> writeExact == $past(regWdata[2]))
      else $error("write-exact bit not written");
   a_en_hold: assert property (@(posedge core_clk) disable iff (!resetn)
      !(regWrite && regAddr == LBC_ADDR_EN_STAT) |=> $stable(enableBit) && $stable(writeExact))
      else $error("enable register changed without write");
   a_sel_write: assert property (@(posedge core_clk) disable iff (!resetn)
      regWrite && regAddr == LBC_ADDR_THR_SEL |=> thresholdSelect == $past(regWdata[5:0]))
      else $error("select not written");
   a_sel_hold: assert property (@(posedge core_clk) disable iff (!resetn)
      !(regWrite && regAddr == LBC_ADDR_THR_SEL) |=> $stable(thresholdSelect))
      else $error("select changed without write");

   // Enable qualification
   a_pb_enable: assert property (@(posedge core_clk) disable iff (!resetn)
      pushPressed |=> converterOn)
      else $error("pushbutton did not enable");
   a_en_pin_on: assert property (@(posedge core_clk) disable iff (!resetn)
      enPinS && enableBit |=> converterOn)
      else $error("pin and bit did not enable");
   a_off_idle: assert property (@(posedge core_clk) disable iff (!resetn)
      !pushPressed && !enPinS |=> !converterOn)
      else $error("converter on without condition");
   a_bit_off: assert property (@(posedge core_clk) disable iff (!resetn)
      !pushPressed && !enableBit |=> !converterOn)
      else $error("converter on with enable bit clear");

   // Power-OK flag
   a_trip_ok: assert property (@(posedge core_clk) disable iff (!resetn)
      tripS |=> !powerOk)
      else $error("power ok while tripped");
   a_ok_good: assert property (@(posedge core_clk) disable iff (!resetn)
      converterOn && !tripS |=> powerOk)
      else $error("power ok missing while good");
   a_ok_off: assert property (@(posedge core_clk) disable iff (!resetn)
      !converterOn |=> !powerOk)
      else $error("power ok while converter off");

   // Threshold decode
   a_top_decode: assert property (@(posedge core_clk) disable iff (!resetn)
      thresholdSelect == LBC_SEL_RESET |=> thresholdQuarterVolts == LBC_QV_RESET)
      else $error("top threshold not 28.5 V");
   a_low_base: assert property (@(posedge core_clk) disable iff (!resetn)
      thresholdSelect == 6'h00 |=> thresholdQuarterVolts == LBC_QV_BASE_LO)
      else $error("lowest threshold not 5 V");
   a_high_base: assert property (@(posedge core_clk) disable iff (!resetn)
      thresholdSelect == 6'h20 |=> thresholdQuarterVolts == LBC_QV_BASE_HI)
      else $error("high range base not 13 V");
   a_top_bound: assert property (@(posedge core_clk) disable iff (!resetn)
      thresholdQuarterVolts <= LBC_QV_RESET)
      else $error("threshold above its top setting");
endmodule : lbc_regs

// ---- lbc_sync.sv ----
// Purpose: Two-flip-flop synchroniser for asynchronous pin levels
// Assumes: Inputs are slow levels
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps
module lbc_sync
   import lbc_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             resetn,
   // Data
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stageOne;

   // Refuse an empty synchroniser
   if (WIDTH < 1) begin : g_width_check
      $error("synchroniser width must be at least one");
   end

   // Two stage shift
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         stageOne <= '0;
         syncOut  <= '0;
      end else begin
         stageOne <= asyncIn;
         syncOut  <= stageOne;
      end
   end
endmodule : lbc_sync

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the boost converter register bank
// Assumes: Pins settle within five cycles of a change
// Notes:   Read-only contents are given distinct values at the instance
`timescale 1ns/1ps
module tb_top import lbc_pkg::*;;
   logic       core_clk = 1'b0;
   logic       resetn   = 1'b0;
   logic       regWrite, enPin = 1'b0, pbN = 1'b1, trip = 1'b0, on;
   logic [7:0] regAddr, regWdata, regRdata, rdv, e;
   logic [6:0] qv;
   logic [5:0] sel;
   int         errors = 0;
   int         checkCount = 0;
   // Clock of 4 ns
   always #2 core_clk = ~core_clk;
   lbc_regs #(.RO_A_VALUE(8'h5a), .RO_B_VALUE(8'hc3), .EN_HI_VALUE(5'h00), .THR_HI_VALUE(2'h2)) lbc_regs_i (
      .core_clk(core_clk), .resetn(resetn), .regWrite(regWrite), .regAddr(regAddr),
      .regWdata(regWdata), .regRdata(regRdata), .converterEnablePin(enPin), .pushbuttonInputN(pbN),
      .overvoltageTrip(trip), .converterOn(on), .thresholdQuarterVolts(qv), .thresholdSelect(sel));
   lbc_host_model lbc_host_model_i (.core_clk(core_clk), .regWrite(regWrite), .regAddr(regAddr),
      .regWdata(regWdata), .regRdata(regRdata));
   task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
      checkCount++;
      if (g !== x) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, x, g);
      end
   endtask : chk
   task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] x);
      lbc_host_model_i.rd(a, rdv);
      chk(nm, x, rdv);
   endtask : rchk
   // Set pins, let them pass the synchroniser, check output and status
   task automatic pins(input logic en, input logic pb, input logic tr, input logic xOn, input logic [7:0] x);
      @(negedge core_clk);
      enPin = en;
      pbN   = pb;
      trip  = tr;
      repeat (5) @(negedge core_clk);
      chk("converter_on", {7'h00, xOn}, {7'h00, on});
      rchk("en_stat", LBC_ADDR_EN_STAT, x);
   endtask : pins
   task automatic give_verdict;
      $display("checks %0d errors %0d", checkCount, errors);
      if (errors == 0 && checkCount > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict
   // Released pushbutton must not enable the converter just after reset
   task automatic test_reset;
      @(negedge core_clk);
      chk("converter_on", 8'h00, {7'h00, on});
      rchk("ro_a", LBC_ADDR_RO_A, 8'h5a);
      rchk("ro_b", LBC_ADDR_RO_B, 8'hc3);
      rchk("thr", LBC_ADDR_THR_SEL, 8'hbf);
      chk("qv", 8'h72, {1'b0, qv});
      $display("test reset done");
   endtask : test_reset
   task automatic test_readonly;
      lbc_host_model_i.wr(LBC_ADDR_RO_A, 8'hff);
      lbc_host_model_i.wr(LBC_ADDR_RO_B, 8'ha5);
      lbc_host_model_i.wr(LBC_ADDR_THR_SEL, 8'hc5);
      rchk("ro_a", LBC_ADDR_RO_A, 8'h5a);
      rchk("ro_b", LBC_ADDR_RO_B, 8'hc3);
      rchk("thr", LBC_ADDR_THR_SEL, 8'h85);
      $display("test readonly done");
   endtask : test_readonly
   // Every select code against the quarter-volt decode
   task automatic test_decode;
      for (int i = 0; i < 64; i++) begin
         lbc_host_model_i.wr(LBC_ADDR_THR_SEL, 8'(i));
         repeat (2) @(negedge core_clk);
         e = (i >= 32) ? 8'(52 + 16 * ((i >> 3) & 3) + 2 * (i & 7)) : 8'(20 + 8 * ((i >> 3) & 3) + (i & 7));
         chk("qv", e, {1'b0, qv});
         chk("sel", 8'(i), {2'h0, sel});
      end
      $display("test decode done");
   endtask : test_decode
   task automatic test_enable;
      lbc_host_model_i.wr(LBC_ADDR_EN_STAT, 8'hff);
      pins(1'b1, 1'b1, 1'b0, 1'b1, 8'h03);
      pins(1'b1, 1'b1, 1'b1, 1'b1, 8'h01);
      pins(1'b0, 1'b1, 1'b0, 1'b0, 8'h01);
      pins(1'b0, 1'b0, 1'b0, 1'b1, 8'h03);
      lbc_host_model_i.wr(LBC_ADDR_EN_STAT, 8'h00);
      pins(1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
      $display("test enable done");
   endtask : test_enable
   // Main sequence
   initial begin
      repeat (10) @(negedge core_clk);
      resetn = 1'b1;
      test_reset();
      test_readonly();
      test_decode();
      test_enable();
      give_verdict();
   end
   // Watchdog well beyond the expected run
   initial begin
      #100000;
      errors++;
      give_verdict();
   end
endmodule : tb_top
